// ===== bench/cdv_clk_partner.sv
// source clocks for the divider chain and a period/high-time monitor
// assumes all levels are sampled on pclk; times are counted in pclk cycles
`timescale 1ns/1ps
`default_nettype none

module cdv_clk_partner (
   input wire logic pclk,
   input wire logic [7:0] ext_per,
   input wire logic [7:0] ext_hi,
   output logic ext_clk,
   output logic osc_clk,
   input wire logic [3:0] chan,
   output logic [15:0] meas_per [4],
   output logic [15:0] meas_hi [4]
);
   logic [7:0] ec = 8'h00;
   logic [3:0] oc = 4'h0;
   logic [3:0] prev = 4'h0;
   logic [15:0] cnt [4];

   initial begin
      ext_clk = 1'b0;
      osc_clk = 1'b0;
      for (int i = 0; i < 4; i++) begin
         cnt[i] = 16'h0000;
         meas_per[i] = 16'h0000;
         meas_hi[i] = 16'h0000;
      end
   end

   // external source with programmable duty, period 10 oscillator at 50%
   always @(posedge pclk) begin
      ec <= (ec + 8'h01 >= ext_per) ? 8'h00 : ec + 8'h01;
      ext_clk <= (ec < ext_hi);
      oc <= (oc == 4'h4) ? 4'h0 : oc + 4'h1;
      if (oc == 4'h4) begin
         osc_clk <= ~osc_clk;
      end
   end

   // a downstream receiver only sees edges: measure rise-to-rise and high time
   always @(posedge pclk) begin
      for (int i = 0; i < 4; i++) begin
         if (chan[i] && !prev[i]) begin
            meas_per[i] <= cnt[i] + 16'h0001;
            cnt[i] <= 16'h0000;
         end else begin
            cnt[i] <= cnt[i] + 16'h0001;
         end
         if (!chan[i] && prev[i]) begin
            meas_hi[i] <= cnt[i] + 16'h0001;
         end
      end
      prev <= chan;
   end
endmodule // cdv_clk_partner

`default_nettype wire

// ===== bench/cdv_clock_divider_chain_test.sv
// self-checking bench: APB configuration, output periods and duty measured
// assumes the partner monitor counts periods and high times in pclk cycles
`timescale 1ns/1ps
`default_nettype none
`include "cdv_regs.svh"

`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
   n_mismatch++; $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end

module clock_divider_chain_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_clk;
   logic osc_clk;
   wire logic [3:0] chan;
   logic [7:0] ext_per = 8'h08;
   logic [7:0] ext_hi = 8'h04;
   logic [15:0] meas_per [4];
   logic [15:0] meas_hi [4];
   int n_tests = 0;
   int n_mismatch = 0;

   cdv_clock_divider_chain DUT (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clk_in(ext_clk), .osc_clk_in(osc_clk),
      .chan0_clk_out(chan[0]), .chan1_clk_out(chan[1]),
      .chan2_clk_out(chan[2]), .chan3_clk_out(chan[3]));

   cdv_clk_partner PARTNER (.pclk(pclk), .ext_per(ext_per), .ext_hi(ext_hi),
      .ext_clk(ext_clk), .osc_clk(osc_clk), .chan(chan),
      .meas_per(meas_per), .meas_hi(meas_hi));

   initial begin
      forever #2.5 pclk = ~pclk;
   end

   task automatic final_report();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [9:0] idx,
                      input logic [7:0] d, output logic [31:0] rd,
                      output logic err);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      // hold the access phase until pready is seen high at an edge
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         `CHK("pready", 1'b1, 1'b0)
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, idx, d, rd, err);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] ex,
                         input logic exerr);
      logic [31:0] rd;
      logic err;
      apb(1'b0, idx, 8'h00, rd, err);
      `CHK("prdata", ex, rd)
      `CHK("pslverr", exerr, err)
   endtask

   // settle over several periods so a change lands at a period boundary
   task automatic meas(input int ch, input logic [15:0] per,
                       input logic [15:0] hi);
      repeat (per * 4 + 60) @(posedge pclk);
      `CHK("period", per, meas_per[ch])
      `CHK("high", hi, meas_hi[ch])
   endtask

   initial begin
      repeat (60000) @(posedge pclk);
      `CHK("watchdog", 1'b0, 1'b1)
      final_report();
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`CDV_IDX_C0_CNT, 32'h00000000, 1'b0);
      rd_chk(`CDV_IDX_C0_COR, 32'h00000000, 1'b0);
      rd_chk(`CDV_IDX_PRE, 32'h00000002, 1'b0);
      rd_chk(10'h3FF, 32'h00000000, 1'b1);
      // ext direct, fields kept legal for correction
      wr(`CDV_IDX_SRC, 8'h01);
      meas(0, 16, 8);
      wr(`CDV_IDX_C0_CNT, 8'h31);
      wr(`CDV_IDX_C0_COR, 8'h01);
      meas(0, 48, 16);
      wr(`CDV_IDX_C0_CNT, 8'h10);
      wr(`CDV_IDX_C0_COR, 8'h00);
      meas(0, 24, 12);
      // prescaler codes with bypassed channel, counts on prescaler output
      wr(`CDV_IDX_SRC, 8'h00);
      wr(`CDV_IDX_C0_BYP, 8'h80);
      wr(`CDV_IDX_C0_COR, 8'h01);
      for (int p = 2; p <= 6; p++) begin
         wr(`CDV_IDX_PRE, p[7:0]);
         meas(0, 8 * p, 8 * (p / 2));
      end
      wr(`CDV_IDX_C0_COR, 8'h00);
      wr(`CDV_IDX_PRE, 8'h03);
      meas(0, 24, 12);
      wr(`CDV_IDX_PRE, 8'h02);
      wr(`CDV_IDX_C0_BYP, 8'h00);
      wr(`CDV_IDX_C0_CNT, 8'h11);
      meas(0, 64, 32);
      // cascaded channels; second stage used only with the first
      wr(`CDV_IDX_21_CNT, 8'h00);
      wr(`CDV_IDX_22_CNT, 8'h11);
      meas(2, 128, 64);
      wr(`CDV_IDX_3_BYP, 8'h30);
      meas(3, 16, 8);
      wr(`CDV_IDX_31_CNT, 8'h10);
      wr(`CDV_IDX_3_BYP, 8'h20);
      meas(3, 48, 24);
      // 25 percent source
      ext_hi <= 8'h02;
      wr(`CDV_IDX_SRC, 8'h01);
      wr(`CDV_IDX_C0_BYP, 8'h80);
      meas(0, 8, 2);
      wr(`CDV_IDX_C1_CNT, 8'h21);
      meas(1, 40, 18);
      wr(`CDV_IDX_SRC, 8'h00);
      wr(`CDV_IDX_PRE, 8'h03);
      meas(0, 24, 10);
      wr(`CDV_IDX_PRE, 8'h05);
      meas(0, 40, 18);
      wr(`CDV_IDX_C0_COR, 8'h02);
      meas(0, 8, 2);
      wr(`CDV_IDX_SRC, 8'h02);
      meas(0, 10, 5);
      final_report();
   end
endmodule // clock_divider_chain_test

`default_nettype wire

// ===== common/cdv_pkg.sv
// types shared by the divider chain
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package cdv_pkg;
   typedef enum logic [1:0] {
      CDV_SRC_EXT_PRE = 2'b00,
      CDV_SRC_EXT_DIR = 2'b01,
      CDV_SRC_OSC_PRE = 2'b10,
      CDV_SRC_BAD = 2'b11
   } cdv_src_type;

   typedef enum logic [1:0] {
      CDV_ST_DELAY = 2'b00,
      CDV_ST_HIGH = 2'b01,
      CDV_ST_LOW = 2'b10
   } cdv_state_type;
endpackage

`default_nettype wire

// ===== common/cdv_regs.svh
// register indices, field positions and reset values of the divider chain
// assumes an APB slave that maps index k to byte address 4*k
`ifndef CDV_REGS_SVH
`define CDV_REGS_SVH

// register indices (byte address = 4 * index)
`define CDV_IDX_C0_CNT 10'h190
`define CDV_IDX_C0_BYP 10'h191
`define CDV_IDX_C0_COR 10'h192
`define CDV_IDX_C1_CNT 10'h196
`define CDV_IDX_C1_BYP 10'h197
`define CDV_IDX_C1_COR 10'h198
`define CDV_IDX_21_CNT 10'h199
`define CDV_IDX_2_DLY 10'h19A
`define CDV_IDX_22_CNT 10'h19B
`define CDV_IDX_2_BYP 10'h19C
`define CDV_IDX_2_COR 10'h19D
`define CDV_IDX_31_CNT 10'h19E
`define CDV_IDX_3_DLY 10'h19F
`define CDV_IDX_32_CNT 10'h1A0
`define CDV_IDX_3_BYP 10'h1A1
`define CDV_IDX_3_COR 10'h1A2
`define CDV_IDX_PRE 10'h1E0
`define CDV_IDX_SRC 10'h1E1
`define CDV_IDX_STAT 10'h1F0

// storage slots
`define CDV_S_C0_CNT 5'h00
`define CDV_S_C0_BYP 5'h01
`define CDV_S_C0_COR 5'h02
`define CDV_S_C1_CNT 5'h03
`define CDV_S_C1_BYP 5'h04
`define CDV_S_C1_COR 5'h05
`define CDV_S_21_CNT 5'h06
`define CDV_S_2_DLY 5'h07
`define CDV_S_22_CNT 5'h08
`define CDV_S_2_BYP 5'h09
`define CDV_S_2_COR 5'h0A
`define CDV_S_31_CNT 5'h0B
`define CDV_S_3_DLY 5'h0C
`define CDV_S_32_CNT 5'h0D
`define CDV_S_3_BYP 5'h0E
`define CDV_S_3_COR 5'h0F
`define CDV_S_PRE 5'h10
`define CDV_S_SRC 5'h11
`define CDV_NSLOT 18

// field positions
`define CDV_F_BYP 7
`define CDV_F_BYP_X1 4
`define CDV_F_BYP_X2 5
`define CDV_F_COR_OFF 0
`define CDV_F_DIRECT 1

// reset values and prescaler ratio limits
`define CDV_RST_REG 8'h00
`define CDV_RST_PRE 8'h02
`define CDV_PRE_MIN 3'h2
`define CDV_PRE_MAX 3'h6

`endif

// ===== rtl/cdv_clock_divider_chain.sv
// prescaler, two single-stage and two cascaded channel dividers, APB regs
// assumes source clock levels sampled on pclk, far slower than pclk
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cdv_regs.svh"

module cdv_div_stage
   import cdv_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_lvl,
   input wire logic bypass,
   input wire logic cor_en,
   input wire logic [3:0] n_cnt,
   input wire logic [3:0] m_cnt,
   input wire logic [3:0] delay,
   output logic out_lvl
);
   cdv_state_type state_r;
   logic in_d_r;
   logic hold_r;
   logic out_r;
   logic [3:0] cnt_r;
   logic [3:0] n_r;
   logic [3:0] m_r;
   logic rise;
   logic fall;
   logic odd;

   assign rise = in_lvl & ~in_d_r;
   assign fall = ~in_lvl & in_d_r;
   assign odd = n_r[0] ^ m_r[0]; // RL8
   assign out_lvl = out_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_d_r <= 1'h0;
      end else begin
         in_d_r <= in_lvl;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= CDV_ST_DELAY;
         cnt_r <= 4'h0;
         n_r <= 4'h0;
         m_r <= 4'h0;
         hold_r <= 1'h0;
         out_r <= 1'h0;
      end else if (bypass) begin
         // counter idle, input passed at division one
         state_r <= CDV_ST_DELAY; // RL3
         cnt_r <= 4'h0;
         hold_r <= 1'h0;
         out_r <= in_lvl; // RL3
      end else begin
         if (state_r == CDV_ST_DELAY) begin
            out_r <= 1'h0;
         end
         if (fall && hold_r) begin
            // corrected odd ratio: high phase ends on the input fall
            hold_r <= 1'h0; // RL12
            out_r <= 1'h0; // RL11
         end
         if (rise) begin // RL6
            case (state_r)
               CDV_ST_DELAY: begin
                  if (cnt_r == delay) begin // RL15
                     state_r <= CDV_ST_HIGH;
                     cnt_r <= 4'h0;
                     out_r <= 1'h1;
                     n_r <= n_cnt;
                     m_r <= m_cnt;
                  end else begin
                     cnt_r <= cnt_r + 4'h1;
                  end
               end
               CDV_ST_HIGH: begin
                  if (cnt_r == n_r) begin // RL4
                     state_r <= CDV_ST_LOW;
                     cnt_r <= 4'h0;
                     if (cor_en && odd) begin
                        hold_r <= 1'h1; // RL7
                     end else begin
                        out_r <= 1'h0; // RL9
                     end
                  end else begin
                     cnt_r <= cnt_r + 4'h1;
                  end
               end
               CDV_ST_LOW: begin
                  if (cnt_r == m_r) begin // RL5
                     state_r <= CDV_ST_HIGH;
                     cnt_r <= 4'h0;
                     out_r <= 1'h1;
                     hold_r <= 1'h0;
                     // new fields apply from the next period only
                     n_r <= n_cnt; // RL18
                     m_r <= m_cnt; // RL18
                  end else begin
                     cnt_r <= cnt_r + 4'h1;
                  end
               end
               default: begin
                  state_r <= CDV_ST_DELAY;
                  cnt_r <= 4'h0;
               end
            endcase
         end
      end
   end

   AST_BYP_FOLLOW: assert property (@(posedge pclk) // RL3
      disable iff (!presetn) bypass |=> out_lvl == $past(in_lvl))
      else $error("bypassed stage does not follow its input");
   AST_HIGH_END: assert property (@(posedge pclk) // RL4
      disable iff (!presetn)
      (!bypass && rise && state_r == CDV_ST_HIGH && cnt_r == n_r
       && !(cor_en && odd)) |=> !out_lvl ##1 !out_lvl)
      else $error("high phase not ended after n plus one rises");
   AST_COR_HOLD: assert property (@(posedge pclk) // RL7
      disable iff (!presetn)
      (!bypass && rise && state_r == CDV_ST_HIGH && cnt_r == n_r
       && cor_en && odd) |=> (out_lvl && hold_r))
      else $error("correction did not extend the high phase");
   AST_COR_RELEASE: assert property (@(posedge pclk) // RL12
      disable iff (!presetn)
      (!bypass && hold_r && fall) |=> (!out_lvl && !hold_r))
      else $error("extended high phase not ended on input fall");
   AST_NO_COR: assert property (@(posedge pclk) // RL9
      disable iff (!presetn) (!cor_en && !hold_r) |=> !hold_r)
      else $error("correction active while disabled");
   AST_LOW_END: assert property (@(posedge pclk) // RL18
      disable iff (!presetn)
      (!bypass && rise && state_r == CDV_ST_LOW && cnt_r == m_r)
      |=> (out_lvl && cnt_r == 4'h0 && n_r == $past(n_cnt)))
      else $error("period restart or field reload missing");
   AST_ON_INPUT: assert property (@(posedge pclk) // RL6
      disable iff (!presetn)
      (!bypass && !rise && !fall && state_r != CDV_ST_DELAY)
      |=> $stable(out_lvl) && $stable(cnt_r))
      else $error("divider moved without an input edge");
   AST_DELAY_LOW: assert property (@(posedge pclk) // RL15
      disable iff (!presetn)
      (!bypass && state_r == CDV_ST_DELAY && !rise) |=> !out_lvl)
      else $error("output left low state during delay");
endmodule // cdv_div_stage

// Operation
// RL1 - with prescaler, total ratio is prescaler ratio times channel ratio
// RL2 - prescaler divides by two to six from a three-bit field
// RL3 - bypass on channel 0 or 1 passes input and idles divider
// RL4 - low for low field plus one, high for high field plus one
// RL5 - active divider divides by both fields plus two, 2 to 32
// RL6 - counts taken on the clock feeding the divider
// RL7 - correction on after reset, off by per-channel disable bit
// RL8 - software sets equal fields for even, low one more for odd
// RL9 - uncorrected duty is high field plus one over the ratio
// RL10 - bypassed with odd prescaler: 33.3 or 40 percent, 50 corrected
// RL11 - corrected odd prescaler duty is (1+X)/3 or (2+X)/5
// RL12 - no prescaler: bypass keeps duty; odd corrected (N+1+X)/(2N+3)
// RL13 - direct oscillator gives 50 percent, direct external keeps duty
// RL14 - channels 2, 3 have two bypassable cascaded stages, ratios multiply
// RL15 - each divider delays its output by selectable input cycles
// RL16 - source select 00 ext+pre, 01 ext, 10 osc+pre, 11 illegal
// RL17 - software uses first cascaded stage, bypasses second when one
// RL18 - counters advance on input rises; new fields apply next period
module cdv_clock_divider_chain
   import cdv_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_clk_in,
   input wire logic osc_clk_in,
   output logic chan0_clk_out,
   output logic chan1_clk_out,
   output logic chan2_clk_out,
   output logic chan3_clk_out
);
   logic [7:0] regs_r [`CDV_NSLOT];
   logic [31:0] prdata_r;
   logic [4:0] slot;
   logic hit;
   logic wr_ok;
   logic [9:0] idx;
   logic [3:0] chan_r;
   cdv_src_type src_sel;
   logic src_lvl;
   logic [2:0] pre_ratio;
   logic [2:0] ratio_fld;
   logic [3:0] pre_n;
   logic [3:0] pre_m;
   logic [7:0] st_in;
   logic [7:0] st_byp;
   logic [7:0] st_cor;
   logic [7:0] st_out;
   logic [3:0] st_n [8];
   logic [3:0] st_m [8];
   logic [3:0] st_dly [8];
   logic [3:0] ch_in;
   logic [3:0] ch_cor;

   // apb slave
   assign idx = paddr[11:2];

   always_comb begin
      hit = 1'h1;
      wr_ok = 1'h1;
      slot = `CDV_S_C0_CNT;
      if (idx == `CDV_IDX_C0_CNT) slot = `CDV_S_C0_CNT;
      else if (idx == `CDV_IDX_C0_BYP) slot = `CDV_S_C0_BYP;
      else if (idx == `CDV_IDX_C0_COR) slot = `CDV_S_C0_COR;
      else if (idx == `CDV_IDX_C1_CNT) slot = `CDV_S_C1_CNT;
      else if (idx == `CDV_IDX_C1_BYP) slot = `CDV_S_C1_BYP;
      else if (idx == `CDV_IDX_C1_COR) slot = `CDV_S_C1_COR;
      else if (idx == `CDV_IDX_21_CNT) slot = `CDV_S_21_CNT;
      else if (idx == `CDV_IDX_2_DLY) slot = `CDV_S_2_DLY;
      else if (idx == `CDV_IDX_22_CNT) slot = `CDV_S_22_CNT;
      else if (idx == `CDV_IDX_2_BYP) slot = `CDV_S_2_BYP;
      else if (idx == `CDV_IDX_2_COR) slot = `CDV_S_2_COR;
      else if (idx == `CDV_IDX_31_CNT) slot = `CDV_S_31_CNT;
      else if (idx == `CDV_IDX_3_DLY) slot = `CDV_S_3_DLY;
      else if (idx == `CDV_IDX_32_CNT) slot = `CDV_S_32_CNT;
      else if (idx == `CDV_IDX_3_BYP) slot = `CDV_S_3_BYP;
      else if (idx == `CDV_IDX_3_COR) slot = `CDV_S_3_COR;
      else if (idx == `CDV_IDX_PRE) slot = `CDV_S_PRE;
      else if (idx == `CDV_IDX_SRC) slot = `CDV_S_SRC;
      else if (idx == `CDV_IDX_STAT) wr_ok = 1'h0;
      else begin
         hit = 1'h0;
         wr_ok = 1'h0;
      end
   end

   // zero wait states: read data is caught in the setup cycle
   assign pready = penable;
   assign pslverr = psel & penable & ~hit;
   assign prdata = prdata_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         if (!hit) prdata_r <= 32'h0;
         else if (!wr_ok) prdata_r <= {28'h0, chan_r};
         else prdata_r <= {24'h0, regs_r[slot]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `CDV_NSLOT; i++) begin
            regs_r[i] <= `CDV_RST_REG; // RL7
         end
         regs_r[`CDV_S_PRE] <= `CDV_RST_PRE;
      end else if (psel && penable && pwrite && wr_ok) begin
         regs_r[slot] <= pwdata[7:0];
      end
   end

   // source and prescaler
   assign src_sel = cdv_src_type'(regs_r[`CDV_S_SRC][1:0]);
   assign ratio_fld = regs_r[`CDV_S_PRE][2:0];

   always_comb begin
      // unlisted field codes clamp into the legal range
      if (ratio_fld < `CDV_PRE_MIN) pre_ratio = `CDV_PRE_MIN; // RL2
      else if (ratio_fld > `CDV_PRE_MAX) pre_ratio = `CDV_PRE_MAX;
      else pre_ratio = ratio_fld;
   end

   // short high half for odd ratios: 3 gives 1 of 3, 5 gives 2 of 5
   assign pre_n = {2'h0, pre_ratio[2:1]} - 4'h1; // RL10
   assign pre_m = {1'h0, pre_ratio} - {2'h0, pre_ratio[2:1]} - 4'h1;

   always_comb begin
      case (src_sel) // RL16
         CDV_SRC_EXT_PRE: src_lvl = ext_clk_in;
         CDV_SRC_EXT_DIR: src_lvl = ext_clk_in;
         CDV_SRC_OSC_PRE: src_lvl = osc_clk_in;
         default: src_lvl = 1'h0;
      endcase
   end

   assign ch_cor[0] = ~regs_r[`CDV_S_C0_COR][`CDV_F_COR_OFF]; // RL7
   assign ch_cor[1] = ~regs_r[`CDV_S_C1_COR][`CDV_F_COR_OFF];
   assign ch_cor[2] = ~regs_r[`CDV_S_2_COR][`CDV_F_COR_OFF];
   assign ch_cor[3] = ~regs_r[`CDV_S_3_COR][`CDV_F_COR_OFF];

   // a corrected channel takes the corrected prescaler output
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         if (src_sel == CDV_SRC_BAD) ch_in[c] = 1'h0; // RL16
         else if (src_sel == CDV_SRC_EXT_DIR) ch_in[c] = ext_clk_in;
         else ch_in[c] = ch_cor[c] ? st_out[1] : st_out[0]; // RL1 RL11
      end
   end

   // stage wiring
   // 0,1 prescaler raw and corrected; 2,3 channels 0,1; 4..7 cascades
   always_comb begin
      st_in = {st_out[6], ch_in[3], st_out[4], ch_in[2],
               ch_in[1], ch_in[0], src_lvl, src_lvl}; // RL14
      st_byp = {regs_r[`CDV_S_3_BYP][`CDV_F_BYP_X2],
                regs_r[`CDV_S_3_BYP][`CDV_F_BYP_X1],
                regs_r[`CDV_S_2_BYP][`CDV_F_BYP_X2],
                regs_r[`CDV_S_2_BYP][`CDV_F_BYP_X1],
                regs_r[`CDV_S_C1_BYP][`CDV_F_BYP],
                regs_r[`CDV_S_C0_BYP][`CDV_F_BYP], 2'h0}; // RL3
      st_cor = {ch_cor[3], ch_cor[3], ch_cor[2], ch_cor[2],
                ch_cor[1], ch_cor[0], 2'h2};
      st_n[0] = pre_n;
      st_m[0] = pre_m;
      st_dly[0] = 4'h0;
      st_n[1] = pre_n;
      st_m[1] = pre_m;
      st_dly[1] = 4'h0;
      st_n[2] = regs_r[`CDV_S_C0_CNT][3:0];
      st_m[2] = regs_r[`CDV_S_C0_CNT][7:4];
      st_dly[2] = regs_r[`CDV_S_C0_BYP][3:0];
      st_n[3] = regs_r[`CDV_S_C1_CNT][3:0];
      st_m[3] = regs_r[`CDV_S_C1_CNT][7:4];
      st_dly[3] = regs_r[`CDV_S_C1_BYP][3:0];
      st_n[4] = regs_r[`CDV_S_21_CNT][3:0];
      st_m[4] = regs_r[`CDV_S_21_CNT][7:4];
      st_dly[4] = regs_r[`CDV_S_2_DLY][3:0];
      st_n[5] = regs_r[`CDV_S_22_CNT][3:0];
      st_m[5] = regs_r[`CDV_S_22_CNT][7:4];
      st_dly[5] = regs_r[`CDV_S_2_DLY][7:4];
      st_n[6] = regs_r[`CDV_S_31_CNT][3:0];
      st_m[6] = regs_r[`CDV_S_31_CNT][7:4];
      st_dly[6] = regs_r[`CDV_S_3_DLY][3:0];
      st_n[7] = regs_r[`CDV_S_32_CNT][3:0];
      st_m[7] = regs_r[`CDV_S_32_CNT][7:4];
      st_dly[7] = regs_r[`CDV_S_3_DLY][7:4];
   end

   for (genvar g = 0; g < 8; g++) begin : g_stage
      cdv_div_stage u_stage (
         .pclk(pclk),
         .presetn(presetn),
         .in_lvl(st_in[g]),
         .bypass(st_byp[g]),
         .cor_en(st_cor[g]),
         .n_cnt(st_n[g]),
         .m_cnt(st_m[g]),
         .delay(st_dly[g]),
         .out_lvl(st_out[g])
      );
   end

   // outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_r <= 4'h0;
      end else begin
         if (regs_r[`CDV_S_C0_COR][`CDV_F_DIRECT]) chan_r[0] <= src_lvl; // RL13
         else chan_r[0] <= st_out[2];
         if (regs_r[`CDV_S_C1_COR][`CDV_F_DIRECT]) chan_r[1] <= src_lvl;
         else chan_r[1] <= st_out[3];
         chan_r[2] <= st_out[5]; // RL14
         chan_r[3] <= st_out[7];
      end
   end

   assign chan0_clk_out = chan_r[0];
   assign chan1_clk_out = chan_r[1];
   assign chan2_clk_out = chan_r[2];
   assign chan3_clk_out = chan_r[3];

   AST_SRC_ILLEGAL: assert property (@(posedge pclk) // RL16
      disable iff (!presetn)
      (src_sel == CDV_SRC_BAD) |-> (ch_in == 4'h0 && !src_lvl))
      else $error("illegal source code still drives the dividers");
   AST_PRE_RATIO: assert property (@(posedge pclk) // RL2
      disable iff (!presetn)
      ({1'h0, pre_n} + {1'h0, pre_m} + 5'h2 == {2'h0, pre_ratio}
       && pre_ratio >= 3'h2 && pre_ratio <= 3'h6))
      else $error("prescaler split does not match its ratio");
   AST_DIRECT: assert property (@(posedge pclk) // RL13
      disable iff (!presetn) regs_r[`CDV_S_C0_COR][`CDV_F_DIRECT]
      |=> chan0_clk_out == $past(src_lvl))
      else $error("direct route does not carry the source");
   AST_CASCADE: assert property (@(posedge pclk) // RL14
      disable iff (!presetn)
      1'h1 |=> chan2_clk_out == $past(st_out[5]) && st_in[5] == st_out[4])
      else $error("cascade stages not chained");
   AST_PRE_FEED: assert property (@(posedge pclk) // RL1
      disable iff (!presetn)
      (src_sel == CDV_SRC_OSC_PRE && !ch_cor[0]) |-> ch_in[0] == st_out[0])
      else $error("channel not fed by the prescaler");
endmodule // cdv_clock_divider_chain

`default_nettype wire
